//--- rtl/afhr_pkg.sv
// package: constants and types for the axis follower with hold and resume
package afhr_pkg;
  localparam int AFHR_POS_W = 32;
  localparam int AFHR_UNWIND_W = 16;
  localparam logic [15:0] AFHR_UNWIND_MIN = 16'h0015;
  localparam logic [4:0] AFHR_DELAY_MAX_MS = 5'h14;
  localparam logic [4:0] AFHR_DELAY_RST = 5'h00;
  localparam int AFHR_CLK_HZ = 10000000;
  localparam int AFHR_MS_PER_S = 1000;
  localparam int AFHR_TICK_MS = 1;
  localparam int AFHR_MS_CYCLES = AFHR_CLK_HZ / AFHR_MS_PER_S * AFHR_TICK_MS;
  localparam logic [31:0] AFHR_MS_CYCLES_C = 32'(AFHR_MS_CYCLES);
  localparam logic [31:0] AFHR_ZERO32 = 32'h00000000;
  localparam logic [2:0] AFHR_MT_JOG = 3'h0;
  localparam logic [2:0] AFHR_MT_REG = 3'h1;
  localparam logic [2:0] AFHR_MT_ABS = 3'h2;
  localparam logic [2:0] AFHR_MT_REL = 3'h3;
  localparam logic [2:0] AFHR_MT_ASM = 3'h4;
  typedef enum logic [3:0] {
    AFHR_IDLE = 4'b0001,
    AFHR_RUN = 4'b0010,
    AFHR_STOPPING = 4'b0100,
    AFHR_HELD = 4'b1000
  } afhr_state_t;
endpackage

//--- rtl/afhr_loop_if.sv
// interface: follower loop settings and result between top and loop module
`timescale 1ns/1ps
`default_nettype none
interface afhr_loop_if;
  logic signed [31:0] target_pos;
  logic signed [31:0] target_vel;
  logic signed [31:0] fb_pos;
  logic [15:0] gain;
  logic [4:0] delay_ms;
  logic circular;
  logic [15:0] unwind;
  logic [31:0] accel;
  logic [31:0] decel;
  logic enable;
  logic signed [31:0] vel_cmd;
  modport ctrl (output target_pos, target_vel, fb_pos, gain, delay_ms, circular, unwind,
    accel, decel, enable, input vel_cmd);
  modport loop (input target_pos, target_vel, fb_pos, gain, delay_ms, circular, unwind,
    accel, decel, enable, output vel_cmd);
endinterface
`default_nettype wire

//--- rtl/afhr_follow_loop.sv
// module: proportional follower loop with delay compensation and rate limit
`timescale 1ns/1ps
`default_nettype none
module afhr_follow_loop
  import afhr_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic ms_tick_in,
  afhr_loop_if.loop lp
);
  logic signed [31:0] vel_reg;
  logic signed [31:0] vel_next;
  logic signed [31:0] pred_pos;
  logic signed [31:0] err;
  logic signed [31:0] wrapped_err;
  logic signed [31:0] demand;
  logic signed [31:0] lead;
  logic signed [31:0] half_unwind;
  // lead: velocity (steps/s) times delay in ms, divided by one thousand
  assign lead = 32'((64'(lp.target_vel) * $signed(64'(lp.delay_ms))) / 64'sd1000);
  assign pred_pos = lp.target_pos + lead; // wraps, no saturation
  assign err = pred_pos - lp.fb_pos;
  assign half_unwind = 32'({16'h0000, lp.unwind} >> 1);
  // circular: take the shortest way round the unwind point
  assign wrapped_err = !lp.circular ? err :
    (err > half_unwind) ? err - 32'({16'h0000, lp.unwind}) :
    (err < -half_unwind) ? err + 32'({16'h0000, lp.unwind}) : err;
  assign demand = lp.target_vel + 32'(wrapped_err * $signed({16'h0000, lp.gain}));
  // rate limit per millisecond: accel going up in magnitude, decel going down
  always_comb begin
    vel_next = vel_reg;
    if (!lp.enable) begin
      if (vel_reg > $signed(lp.decel)) vel_next = vel_reg - $signed(lp.decel);
      else if (vel_reg < -$signed(lp.decel)) vel_next = vel_reg + $signed(lp.decel);
      else vel_next = AFHR_ZERO32;
    end else if (demand > vel_reg) begin
      if (demand - vel_reg > $signed(vel_reg >= 0 ? lp.accel : lp.decel))
        vel_next = vel_reg + $signed(vel_reg >= 0 ? lp.accel : lp.decel);
      else vel_next = demand;
    end else begin
      if (vel_reg - demand > $signed(vel_reg > 0 ? lp.decel : lp.accel))
        vel_next = vel_reg - $signed(vel_reg > 0 ? lp.decel : lp.accel);
      else vel_next = demand;
    end
  end
  // velocity steps once per millisecond (accel units are steps/s/ms)
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) vel_reg <= AFHR_ZERO32;
    else if (ms_tick_in) vel_reg <= vel_next;
  end
  assign lp.vel_cmd = vel_reg;
endmodule
`default_nettype wire

//--- rtl/afhr_top.sv
// top: axis follower and hold/resume move control
`timescale 1ns/1ps
`default_nettype none
module afhr_top
  import afhr_pkg::*;
#(
  parameter int MS_CYCLES = AFHR_MS_CYCLES
)(
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic follow_en_in,
  input wire logic circular_in,
  input wire logic use_encoder_in,
  input wire logic [15:0] gain_in,
  input wire logic [4:0] delay_ms_in,
  input wire logic [15:0] unwind_in,
  input wire logic axis_update_in,
  input wire logic signed [31:0] axis_pos_in,
  input wire logic signed [31:0] axis_vel_in,
  input wire logic signed [31:0] motor_pos_in,
  input wire logic signed [31:0] encoder_pos_in,
  input wire logic move_start_in,
  input wire logic [2:0] move_type_in,
  input wire logic indexed_in,
  input wire logic signed [31:0] move_target_in,
  input wire logic [31:0] accel_in,
  input wire logic [31:0] decel_in,
  input wire logic [31:0] speed_in,
  input wire logic param_write_in,
  input wire logic param_error_in,
  input wire logic hold_in,
  input wire logic resume_in,
  input wire logic fault_in,
  input wire logic err_clear_in,
  input wire logic stopped_in,
  output logic signed [31:0] vel_cmd_out,
  output logic move_run_out,
  output logic move_stop_out,
  output logic [2:0] move_type_out,
  output logic signed [31:0] move_target_out,
  output logic [31:0] accel_out,
  output logic [31:0] decel_out,
  output logic [31:0] speed_out,
  output logic held_out,
  output logic hold_error_out,
  output logic cmd_error_out,
  output logic cfg_error_out,
  output logic asm_profile_valid_out
);
  afhr_loop_if lpif ();
  afhr_state_t state_reg;
  afhr_state_t state_next;
  logic [31:0] ms_cnt_reg;
  logic ms_tick;
  logic signed [31:0] tpos_reg;
  logic signed [31:0] tvel_reg;
  logic [15:0] gain_reg;
  logic [4:0] delay_reg;
  logic [15:0] unwind_reg;
  logic circ_reg;
  logic enc_reg;
  logic [2:0] mtype_reg;
  logic signed [31:0] mtarget_reg;
  logic [31:0] accel_reg;
  logic [31:0] decel_reg;
  logic [31:0] speed_reg;
  logic herr_reg;
  logic cmd_err_reg;
  logic cfg_err_reg;
  logic asm_valid_reg;
  logic resume_ok;
  logic resume_bad;
  logic start_ok;
  logic held_param_ok;
  logic cfg_bad;
  logic signed [31:0] upd_pos;

  // resume allowed only for held jog/abs/rel with no error while held
  function automatic logic afhr_resumable(input logic [2:0] t);
    afhr_resumable = (t == AFHR_MT_JOG) || (t == AFHR_MT_ABS) || (t == AFHR_MT_REL);
  endfunction

  // millisecond tick from the system clock
  assign ms_tick = (ms_cnt_reg == 32'(MS_CYCLES - 1));
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) ms_cnt_reg <= AFHR_ZERO32;
    else ms_cnt_reg <= ms_tick ? AFHR_ZERO32 : ms_cnt_reg + 32'h00000001;
  end

  // configuration checks: delay above 20, or unwind below 21 when circular, refused
  assign cfg_bad = (delay_ms_in > AFHR_DELAY_MAX_MS) ||
    (circular_in && (unwind_in < AFHR_UNWIND_MIN));
  // circular target shifted by one unwind toward 0..unwind-1
  assign upd_pos = (circ_reg && axis_pos_in >= $signed({16'h0000, unwind_reg})) ?
    axis_pos_in - $signed({16'h0000, unwind_reg}) :
    (circ_reg && axis_pos_in < 0) ? axis_pos_in + $signed({16'h0000, unwind_reg}) :
    axis_pos_in;

  // follower settings latched while the loop is off and config is good, targets per axis update
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      tpos_reg <= AFHR_ZERO32;
      tvel_reg <= AFHR_ZERO32;
      gain_reg <= 16'h0001;
      delay_reg <= AFHR_DELAY_RST;
      unwind_reg <= 16'hffff;
      circ_reg <= 1'b0;
      enc_reg <= 1'b0;
      cfg_err_reg <= 1'b0;
    end else begin
      cfg_err_reg <= cfg_bad;
      if (!follow_en_in && !cfg_bad) begin
        gain_reg <= gain_in;
        delay_reg <= delay_ms_in;
        unwind_reg <= unwind_in;
        circ_reg <= circular_in;
        enc_reg <= use_encoder_in;
      end
      if (axis_update_in) begin
        tpos_reg <= upd_pos;
        tvel_reg <= axis_vel_in;
      end
    end
  end

  assign lpif.target_pos = tpos_reg;
  assign lpif.target_vel = tvel_reg;
  assign lpif.fb_pos = enc_reg ? encoder_pos_in : motor_pos_in;
  assign lpif.gain = gain_reg;
  assign lpif.delay_ms = delay_reg;
  assign lpif.circular = circ_reg;
  assign lpif.unwind = unwind_reg;
  assign lpif.accel = accel_reg;
  assign lpif.decel = decel_reg;
  assign lpif.enable = follow_en_in && !cfg_err_reg && (state_reg == AFHR_IDLE);

  afhr_follow_loop afhr_follow_loop_i (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .ms_tick_in(ms_tick),
    .lp(lpif.loop)
  );

  // hold/resume decisions
  assign start_ok = move_start_in && !hold_in && !fault_in;
  assign resume_ok = resume_in && (state_reg == AFHR_HELD) && !herr_reg &&
    afhr_resumable(mtype_reg);
  assign resume_bad = resume_in && !resume_ok;
  assign held_param_ok = param_write_in && !param_error_in && (state_reg == AFHR_HELD);

  // move state machine
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      AFHR_IDLE: begin
        if (start_ok) state_next = AFHR_RUN;
      end
      AFHR_RUN: begin
        if (fault_in) state_next = AFHR_IDLE;
        else if (hold_in) state_next = AFHR_STOPPING;
        else if (stopped_in) state_next = AFHR_IDLE;
      end
      AFHR_STOPPING: begin
        if (stopped_in) state_next = AFHR_HELD;
      end
      AFHR_HELD: begin
        if (start_ok) state_next = AFHR_RUN;
        else if (resume_ok) state_next = AFHR_RUN;
        else if (!afhr_resumable(mtype_reg)) state_next = AFHR_IDLE;
      end
      default: state_next = AFHR_IDLE;
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) state_reg <= AFHR_IDLE;
    else state_reg <= state_next;
  end

  // move parameters: new start loads all, held write loads speeds only
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      mtype_reg <= AFHR_MT_JOG;
      mtarget_reg <= AFHR_ZERO32;
      accel_reg <= AFHR_ZERO32;
      decel_reg <= AFHR_ZERO32;
      speed_reg <= AFHR_ZERO32;
    end else if (start_ok && (state_reg == AFHR_IDLE || state_reg == AFHR_HELD)) begin
      mtype_reg <= move_type_in;
      mtarget_reg <= move_target_in;
      accel_reg <= accel_in;
      decel_reg <= decel_in;
      speed_reg <= speed_in;
    end else if (held_param_ok && afhr_resumable(mtype_reg)) begin
      accel_reg <= accel_in;
      decel_reg <= decel_in;
      speed_reg <= speed_in; // target kept
    end else if (param_write_in && state_reg == AFHR_IDLE) begin
      accel_reg <= accel_in;
      decel_reg <= decel_in;
    end
  end

  // hold error: set by fault or bad parameters while stopping or held, set beats clear
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) herr_reg <= 1'b0;
    else if ((state_reg == AFHR_HELD || state_reg == AFHR_STOPPING) &&
      (fault_in || (param_write_in && param_error_in))) herr_reg <= 1'b1;
    else if (start_ok || err_clear_in) herr_reg <= 1'b0;
  end

  // command error sticky, set wins over clear
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) cmd_err_reg <= 1'b0;
    else if (resume_bad) cmd_err_reg <= 1'b1;
    else if (err_clear_in) cmd_err_reg <= 1'b0;
  end

  // assembled profile stays valid across hold
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) asm_valid_reg <= 1'b0;
    else if (start_ok && move_type_in == AFHR_MT_ASM) asm_valid_reg <= 1'b1;
  end

  assign vel_cmd_out = lpif.vel_cmd;
  assign move_run_out = (state_reg == AFHR_RUN);
  assign move_stop_out = (state_reg == AFHR_STOPPING);
  assign move_type_out = mtype_reg;
  assign move_target_out = mtarget_reg;
  assign accel_out = accel_reg;
  assign decel_out = decel_reg;
  assign speed_out = speed_reg;
  assign held_out = (state_reg == AFHR_HELD);
  assign hold_error_out = herr_reg;
  assign cmd_error_out = cmd_err_reg;
  assign cfg_error_out = cfg_err_reg;
  assign asm_profile_valid_out = asm_valid_reg;

  // hold requests reach stopping state next cycle regardless of indexed bit
  sequence s_hold_req;
    state_reg == AFHR_RUN && hold_in && !fault_in;
  endsequence
  AST_HOLD_ACTS: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    s_hold_req |=> move_stop_out) else $error("hold not acted on");
  AST_STOP_TO_HELD: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    move_stop_out && stopped_in |=> state_reg == AFHR_HELD) else $error("no held state");
  AST_RESUME_ERR: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    resume_in && !held_out |=> cmd_error_out) else $error("bad resume not flagged");
  AST_NO_REG_RESUME: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    held_out && mtype_reg == AFHR_MT_REG && resume_in && !move_start_in |=> !move_run_out)
    else $error("registration resumed");
  AST_ASM_ENDS: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    held_out && mtype_reg == AFHR_MT_ASM && !move_start_in |=> state_reg == AFHR_IDLE)
    else $error("assembled held not ended");
  AST_TARGET_KEPT: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    held_out && !move_start_in |=> $stable(move_target_out)) else $error("target changed");
  AST_HELD_PARAMS: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    held_out && param_write_in && !param_error_in && !move_start_in &&
    mtype_reg == AFHR_MT_JOG |=> speed_out == $past(speed_in)) else $error("jog param lost");
  AST_HERR_BLOCKS: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    held_out && hold_error_out && resume_in && !move_start_in |=> !move_run_out)
    else $error("resume after error");
  AST_NEW_MOVE: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    held_out && move_start_in && !hold_in && !fault_in |=> move_run_out)
    else $error("new move refused");

  // hold with the indexed bit set must still act at once
  sequence s_hold_idx;
    state_reg == AFHR_RUN && hold_in && indexed_in && !fault_in;
  endsequence
  AST_HOLD_INDEXED: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    s_hold_idx |=> move_stop_out) else $error("indexed hold not acted on");
  // refused settings, bad held parameters and sticky flags
  AST_CFG_REFUSED: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    cfg_bad |=> cfg_error_out) else $error("bad config not flagged");
  AST_HELD_ERR_SET: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (held_out || move_stop_out) && param_write_in && param_error_in |=> hold_error_out)
    else $error("held param error not flagged");
  AST_CMD_STICKY: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    cmd_error_out && !err_clear_in |=> cmd_error_out) else $error("command error lost");
  AST_ASM_KEPT: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    asm_profile_valid_out |=> asm_profile_valid_out) else $error("assembled profile lost");
endmodule
`default_nettype wire

//--- verification/afhr_host_model.sv
// host model: periodic axis updates of position and velocity
`timescale 1ns/1ps
`default_nettype none
module afhr_host_model
  import afhr_pkg::*;
#(
  parameter int UPD_CYCLES = 20
)(
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic send_en_in,
  input wire logic signed [31:0] pos_in,
  input wire logic signed [31:0] vel_in,
  output logic axis_update_out,
  output logic signed [31:0] axis_pos_out,
  output logic signed [31:0] axis_vel_out
);
  int cnt;
  // one update pulse every UPD_CYCLES, driven off the sampling edge
  always @(negedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cnt <= 0;
      axis_update_out <= 1'b0;
    end else begin
      cnt <= (cnt == UPD_CYCLES - 1) ? 0 : cnt + 1;
      axis_update_out <= send_en_in && (cnt == 0);
    end
  end
  // words are whole signed 32-bit values, garbage outside the pulse
  assign axis_pos_out = axis_update_out ? pos_in : ~pos_in;
  assign axis_vel_out = axis_update_out ? vel_in : ~vel_in;
endmodule
`default_nettype wire

//--- verification/afhr_top_test.sv
// testbench: follower loop, configuration checks and hold/resume moves
`timescale 1ns/1ps
`default_nettype none
module afhr_top_test;
  import afhr_pkg::*;
  localparam int RES = 200;
  localparam logic [31:0] ACC = 32'(RES / 10);
  logic clk_in, rst_b_in, follow_en, circ, use_enc, upd, send;
  logic [15:0] gain, unwind;
  logic [4:0] dly;
  logic signed [31:0] apos, avel, hpos, mpos, epos, tgt, vel;
  logic start, idx, pwr, perr, hold, res, fault, clr, stp;
  logic [2:0] mtype, mt_o;
  logic [31:0] acc, dec, spd, acc_o, dec_o, spd_o;
  logic signed [31:0] tgt_o;
  logic run_o, stop_o, held_o, herr_o, cerr_o, cfg_o, asm_o;
  int fail_count, comparisons;
  afhr_host_model afhr_host_model_i (.clk_in(clk_in), .rst_b_in(rst_b_in),
    .send_en_in(send), .pos_in(hpos), .vel_in(32'sh0), .axis_update_out(upd),
    .axis_pos_out(apos), .axis_vel_out(avel));
  afhr_top #(.MS_CYCLES(10)) afhr_top_i (.clk_in(clk_in), .rst_b_in(rst_b_in),
    .follow_en_in(follow_en), .circular_in(circ), .use_encoder_in(use_enc),
    .gain_in(gain), .delay_ms_in(dly), .unwind_in(unwind), .axis_update_in(upd),
    .axis_pos_in(apos), .axis_vel_in(avel), .motor_pos_in(mpos),
    .encoder_pos_in(epos), .move_start_in(start), .move_type_in(mtype),
    .indexed_in(idx), .move_target_in(tgt), .accel_in(acc), .decel_in(dec),
    .speed_in(spd), .param_write_in(pwr), .param_error_in(perr), .hold_in(hold),
    .resume_in(res), .fault_in(fault), .err_clear_in(clr), .stopped_in(stp),
    .vel_cmd_out(vel), .move_run_out(run_o), .move_stop_out(stop_o),
    .move_type_out(mt_o), .move_target_out(tgt_o), .accel_out(acc_o),
    .decel_out(dec_o), .speed_out(spd_o), .held_out(held_o),
    .hold_error_out(herr_o), .cmd_error_out(cerr_o), .cfg_error_out(cfg_o),
    .asm_profile_valid_out(asm_o));
  // 10 MHz clock
  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end
  task results;
    $display("checks %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk_word(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task chk_flag(input logic g, input logic e);
    chk_word({31'h0, g}, {31'h0, e});
  endtask
  task st(input logic r, input logic s, input logic h);
    chk_flag(run_o, r);
    chk_flag(stop_o, s);
    chk_flag(held_o, h);
  endtask
  // one-cycle command pulses: start hold resume write clear stopped
  task go(input logic [5:0] m);
    @(negedge clk_in);
    {stp, clr, pwr, res, hold, start} = m;
    @(negedge clk_in);
    {stp, clr, pwr, res, hold, start} = 6'h00;
  endtask
  // two back-to-back command pulses, one cycle each
  task go2(input logic [5:0] m1, input logic [5:0] m2);
    @(negedge clk_in);
    {stp, clr, pwr, res, hold, start} = m1;
    @(negedge clk_in);
    {stp, clr, pwr, res, hold, start} = m2;
    @(negedge clk_in);
    {stp, clr, pwr, res, hold, start} = 6'h00;
  endtask
  // bounded wait for the follower velocity to take a sign
  task wait_vel(input logic neg);
    int i;
    for (i = 0; i < 3000; i++) begin
      @(negedge clk_in);
      if (vel !== 32'sh0 && vel[31] === neg) break;
    end
    if (i == 3000) begin
      fail_count++;
      results();
    end
  endtask
  // main sequence
  initial begin
    fail_count = 0;
    comparisons = 0;
    rst_b_in = 1'b0;
    {follow_en, circ, use_enc, send, idx, fault, perr} = 7'h00;
    {start, pwr, hold, res, clr, stp} = 6'h00;
    gain = 16'h0002;
    unwind = 16'hffff;
    dly = AFHR_DELAY_RST;
    {hpos, mpos, epos, tgt} = {32'sh3e8, 32'sh0, 32'sh0, 32'sh0};
    {mtype, acc, dec, spd} = {AFHR_MT_JOG, ACC, ACC, 32'h1f4};
    repeat (12) @(negedge clk_in);
    rst_b_in = 1'b1;
    go(6'h00);
    st(1'b0, 1'b0, 1'b0);
    chk_flag(cfg_o, 1'b0);
    chk_word(vel, 32'h0);
    // illegal delay and unwind, then the legal boundaries
    dly = 5'h15;
    go(6'h00);
    chk_flag(cfg_o, 1'b1);
    dly = AFHR_DELAY_MAX_MS;
    {circ, unwind} = {1'b1, 16'h0014};
    go(6'h10);
    go(6'h00);
    chk_flag(cfg_o, 1'b1);
    unwind = AFHR_UNWIND_MIN;
    go(6'h10);
    go(6'h00);
    chk_flag(cfg_o, 1'b0);
    {circ, dly} = {1'b0, AFHR_DELAY_RST};
    // settings latch and follower accel/decel load while the loop is off
    go(6'h08);
    chk_word(acc_o, ACC);
    // linear follow on motor position: ramp limited by accel per ms
    {follow_en, send} = 2'b11;
    wait_vel(1'b0);
    chk_flag(vel <= $signed(ACC), 1'b1);
    // circular on encoder: target 150 rolls to 50, encoder at 60
    follow_en = 1'b0;
    {circ, use_enc, gain, unwind} = {1'b1, 1'b1, 16'h0014, 16'h0064};
    {hpos, mpos, epos} = {32'sh96, 32'sh0, 32'sh3c};
    go(6'h00);
    follow_en = 1'b1;
    wait_vel(1'b1);
    {follow_en, send} = 2'b00;
    // resume with nothing held is refused
    go(6'h04);
    chk_flag(cerr_o, 1'b1);
    go(6'h10);
    chk_flag(cerr_o, 1'b0);
    // jog: hold, new speeds while held, resume
    go(6'h01);
    st(1'b1, 1'b0, 1'b0);
    chk_word(acc_o, ACC);
    go(6'h02);
    st(1'b0, 1'b1, 1'b0);
    go(6'h20);
    st(1'b0, 1'b0, 1'b1);
    {acc, dec, spd} = {32'h28, 32'h32, 32'h384};
    go(6'h08);
    chk_word(acc_o, 32'h28);
    chk_word(dec_o, 32'h32);
    chk_word(spd_o, 32'h384);
    go(6'h04);
    st(1'b1, 1'b0, 1'b0);
    chk_flag(cerr_o, 1'b0);
    idx = 1'b1;
    go(6'h02);
    st(1'b0, 1'b1, 1'b0);
    idx = 1'b0;
    go(6'h20);
    // absolute move from the held position, new target ignored
    {mtype, tgt} = {AFHR_MT_ABS, 32'sh1b58};
    go(6'h01);
    st(1'b1, 1'b0, 1'b0);
    chk_word(32'(mt_o), 32'(AFHR_MT_ABS));
    go(6'h02);
    go(6'h20);
    {tgt, spd} = {32'sh9, 32'h12c};
    go(6'h08);
    chk_word(spd_o, 32'h12c);
    chk_word(tgt_o, 32'h1b58);
    go(6'h04);
    st(1'b1, 1'b0, 1'b0);
    // fault while held sets the hold error and blocks resume, flagged as a command error
    go(6'h02);
    go(6'h20);
    @(negedge clk_in);
    fault = 1'b1;
    @(negedge clk_in);
    fault = 1'b0;
    chk_flag(herr_o, 1'b1);
    go(6'h04);
    chk_flag(cerr_o, 1'b1);
    st(1'b0, 1'b0, 1'b1);
    go(6'h10);
    // parameters written with an error while held are refused and flagged
    {perr, spd} = {1'b1, 32'h1};
    go(6'h08);
    perr = 1'b0;
    chk_flag(herr_o, 1'b1);
    chk_word(spd_o, 32'h12c);
    go(6'h10);
    mtype = AFHR_MT_REL;
    go(6'h01);
    st(1'b1, 1'b0, 1'b0);
    // registration and assembled moves end on hold
    for (int k = 0; k < 2; k++) begin
      mtype = (k == 0) ? AFHR_MT_REG : AFHR_MT_ASM;
      go(6'h02);
      go(6'h20);
      go(6'h01);
      st(1'b1, 1'b0, 1'b0);
      go(6'h02);
      go2(6'h20, 6'h04);
      chk_flag(cerr_o, 1'b1);
      st(1'b0, 1'b0, 1'b0);
      go(6'h10);
      go(6'h04);
      chk_flag(cerr_o, 1'b1);
      go(6'h10);
    end
    chk_flag(asm_o, 1'b1);
    go(6'h01);
    st(1'b1, 1'b0, 1'b0);
    results();
  end
endmodule
`default_nettype wire
